// ==== dv/ctsr_scanner.sv ====
// Scanner model: drives the cyclic link level and control-word pulses.
// Assumes the bench calls its tasks just after a rising edge.
`timescale 1ns/1ps
module ctsr_scanner (
    // Clock
    input wire logic sys_clk_in,
    // Cyclic link
    output logic link_up_out,
    output logic ctl_valid_out,
    output logic [15:0] ctl_word_out,
    output logic [31:0] ctl_target_out
);
    initial begin
        link_up_out = 1'b0;
        ctl_valid_out = 1'b0;
        ctl_word_out = 16'hFFFF;
        ctl_target_out = 32'hFFFFFFFF;
    end
    // Link level changes just after an edge
    task automatic link(logic up);
        @(posedge sys_clk_in);
        #1 link_up_out = up;
    endtask
    // One word; data inverted after so stale values never look valid
    task automatic send(logic [15:0] w, logic [31:0] t);
        @(posedge sys_clk_in);
        #1;
        ctl_word_out = w;
        ctl_target_out = t;
        ctl_valid_out = 1'b1;
        @(posedge sys_clk_in);
        #1;
        ctl_word_out = ~w;
        ctl_target_out = ~t;
        ctl_valid_out = 1'b0;
    endtask
endmodule

// ==== dv/ctsr_top_monitor.sv ====
// Checker for the safe-run supervisor, bound into ctsr_top.
// Sees only top ports; shadows parameter writes itself.
`timescale 1ns/1ps
module ctsr_top_monitor
    import ctsr_pkg::*;
#(
    parameter int SEC_CYCLES = CTSR_SEC_CYC
) (
    // Clock, reset, parameter port
    input wire logic sys_clk_in, rst_n_in, par_wr_in,
    input wire logic [7:0] par_addr_in,
    input wire logic [15:0] par_wdata_in, par_rdata_out,
    // Cyclic link and motion
    input wire logic link_up_in, ctl_valid_in, run_done_in, run_fail_in, save_req_out,
    input wire logic [15:0] ctl_word_in,
    input wire logic [31:0] ctl_target_in,
    input wire ctsr_cmd_t cmd_out,
    input wire logic [2:0] state_out
);
    logic [15:0] cfg_q, lw_q;
    logic [31:0] safe_q;
    logic hv_q;
    wire rs_w = par_wr_in && par_addr_in == CTSR_OFS_DELIVERY && par_wdata_in == CTSR_CMD_RESTORE;
    wire same_w = hv_q && ctl_word_in == lw_q;
    // Shadow of config and safe target
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || rs_w) begin
            cfg_q <= CTSR_CFG_RST;
            safe_q <= CTSR_SAFE_RST;
        end else if (par_wr_in && par_addr_in == CTSR_OFS_CFG) begin
            cfg_q <= par_wdata_in;
        end else if (par_wr_in && par_addr_in == CTSR_OFS_SAFE_LO) begin
            safe_q[15:0] <= par_wdata_in;
        end else if (par_wr_in && par_addr_in == CTSR_OFS_SAFE_HI) begin
            safe_q[31:16] <= par_wdata_in;
        end
    end
    // Last word; restore keeps it so an old word stays old
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            {hv_q, lw_q} <= 17'h00000;
        end else if (ctl_valid_in) begin
            {hv_q, lw_q} <= {1'b1, ctl_word_in};
        end
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_drop;
        $fell(link_up_in) && state_out == CTSR_ST_LINKED;
    endsequence
    sequence s_quiet;
        (!cmd_out.start && !cmd_out.abort) [*3];
    endsequence
    a_restore_save: assert property (rs_w |=> save_req_out)
        else $error("no save after restore");
    a_restore_mid: assert property (rs_w |=> cmd_out.start && cmd_out.kind == CTSR_MV_MID && state_out == CTSR_ST_MID)
        else $error("no mid run after restore");
    a_safe_target: assert property (cmd_out.start && cmd_out.kind == CTSR_MV_SAFE |-> cmd_out.target == safe_q)
        else $error("safe run target wrong");
    a_mid_hold: assert property (state_out == CTSR_ST_MID && ctl_valid_in && same_w |=> s_quiet)
        else $error("unchanged word acted on in mid run");
    a_mid_change: assert property (state_out == CTSR_ST_MID && ctl_valid_in && !same_w |-> ##[1:2] (cmd_out.abort && !cmd_out.start))
        else $error("changed word did not stop mid run");
    a_boot_no_abort: assert property (state_out == CTSR_ST_BOOT |-> !cmd_out.abort)
        else $error("loss reaction without link");
    a_loss_abort: assert property (s_drop ##0 cfg_q[1:0] == CTSR_LOSS_ABORT |-> ##[1:2] cmd_out.abort)
        else $error("no abort on link loss");
    a_loss_safe: assert property (s_drop ##0 cfg_q[1:0] == CTSR_LOSS_SAFE |-> ##[1:2] (cmd_out.start && cmd_out.kind == CTSR_MV_SAFE))
        else $error("no safe run on link loss");
    a_loss_quiet: assert property (s_drop ##0 cfg_q[1:0] inside {2'h0, 2'h3} |=> s_quiet)
        else $error("command on link loss with continue");
endmodule
bind ctsr_top ctsr_top_monitor #(.SEC_CYCLES(SEC_CYCLES)) u_ctsr_top_monitor (.sys_clk_in, .rst_n_in, .par_wr_in,
    .par_addr_in, .par_wdata_in, .par_rdata_out, .link_up_in, .ctl_valid_in, .run_done_in, .run_fail_in,
    .save_req_out, .ctl_word_in, .ctl_target_in, .cmd_out, .state_out);

// ==== dv/test_connection_timeout_safe_run.sv ====
// Bench for the safe-run supervisor with a scanner model.
// Assumes SEC_CYCLES of 10, so a second is ten clocks.
`timescale 1ns/1ps
module test_connection_timeout_safe_run;
    import ctsr_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, done = 1'b0, fail = 1'b0, save, link, vld;
    logic [7:0] addr = 8'h00;
    logic [15:0] wd = 16'h0000, rd, cw;
    logic [31:0] ct;
    logic [2:0] st;
    ctsr_cmd_t cmd;
    logic [15:0] lc [2] = '{16'h0000, 16'h0003};
    int miscompares = 0, total_checks = 0, n_st = 0, n_ab = 0, n_sv = 0, cyc = 0, rel, c0, s0, a0;
    always #12.5 sys_clk = ~sys_clk;
    // Event counters; pulses are one cycle so a count is exact
    always @(posedge sys_clk) begin
        cyc++;
        n_st += (cmd.start === 1'b1);
        n_ab += (cmd.abort === 1'b1);
        n_sv += (save === 1'b1);
    end
    ctsr_top #(.SEC_CYCLES(10)) u_ctsr_top (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .par_wr_in(wr),
        .par_addr_in(addr), .par_wdata_in(wd), .par_rdata_out(rd), .link_up_in(link), .ctl_valid_in(vld),
        .ctl_word_in(cw), .ctl_target_in(ct), .run_done_in(done), .run_fail_in(fail), .cmd_out(cmd),
        .save_req_out(save), .state_out(st));
    ctsr_scanner u_ctsr_scanner (.sys_clk_in(sys_clk), .link_up_out(link), .ctl_valid_out(vld),
        .ctl_word_out(cw), .ctl_target_out(ct));
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic pw(logic [7:0] a, logic [15:0] d);
        addr = a;
        wd = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        tick(1);
    endtask
    task automatic pr(logic [7:0] a, logic [15:0] e);
        addr = a;
        tick(2);
        chk("rdata", rd, e);
    endtask
    task automatic pulse(bit f);
        fail = f;
        done = !f;
        tick(1);
        fail = 1'b0;
        done = 1'b0;
        tick(1);
    endtask
    // Bounded wait for one start pulse, then its kind and target
    task automatic wstart(ctsr_mv_t k, logic [31:0] t, int lim);
        int n0;
        n0 = n_st;
        repeat (lim) if (n_st == n0) tick(1);
        chk("start", n_st - n0, 1);
        chk("kind", cmd.kind, k);
        chk("target", cmd.target, t);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        pr(CTSR_OFS_CFG, 16'h0001);
        pr(CTSR_OFS_SAFE_HI, 16'h0000);
        pr(CTSR_OFS_REPEAT, 16'h0000);
        pr(8'h10, 16'h0000);
        pw(CTSR_OFS_SAFE_LO, 16'h0010);
        pw(CTSR_OFS_SAFE_HI, 16'h8000);
        pw(CTSR_OFS_REPEAT, 16'h0002);
        pw(CTSR_OFS_CFG, 16'h0006);
        // The delay choice restarts the power-up count, so time it from here
        rel = cyc;
        wstart(CTSR_MV_SAFE, 32'h80000010, 200);
        chk("delay", (cyc - rel) inside {[145:160]}, 1);
        c0 = cyc;
        pulse(1'b1);
        wstart(CTSR_MV_SAFE, 32'h80000010, 40);
        chk("retry", (cyc - c0) inside {[18:24]}, 1);
        pulse(1'b0);
        $display("test power-up done");
        // Second reset; link made before the 15 s delay runs out
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        pw(CTSR_OFS_CFG, 16'h0005);
        u_ctsr_scanner.link(1'b1);
        s0 = n_st;
        tick(200);
        chk("no start", n_st - s0, 0);
        chk("state", st, CTSR_ST_LINKED);
        u_ctsr_scanner.send(16'h0014, 32'h00001234);
        wstart(CTSR_MV_TARGET, 32'h00001234, 5);
        a0 = n_ab;
        u_ctsr_scanner.link(1'b0);
        tick(3);
        chk("abort", n_ab - a0, 1);
        u_ctsr_scanner.link(1'b1);
        pw(CTSR_OFS_CFG, 16'h0002);
        u_ctsr_scanner.link(1'b0);
        wstart(CTSR_MV_SAFE, 32'h00000000, 5);
        s0 = n_st;
        pulse(1'b1);
        tick(40);
        chk("no retry", n_st - s0, 0);
        pulse(1'b0);
        u_ctsr_scanner.link(1'b1);
        foreach (lc[i]) begin
            pw(CTSR_OFS_CFG, lc[i]);
            {s0, a0} = {n_st, n_ab};
            u_ctsr_scanner.link(1'b0);
            tick(5);
            chk("quiet", n_st - s0 + n_ab - a0, 0);
            chk("state", st, CTSR_ST_LOST);
            u_ctsr_scanner.link(1'b1);
            tick(2);
        end
        $display("test link loss done");
        u_ctsr_scanner.send(16'h0015, 32'h00000055);
        wstart(CTSR_MV_TARGET, 32'h00000055, 5);
        c0 = n_sv;
        pw(CTSR_OFS_DELIVERY, CTSR_CMD_RESTORE);
        chk("save", n_sv - c0, 1);
        chk("state", st, CTSR_ST_MID);
        pr(CTSR_OFS_CFG, 16'h0001);
        {s0, a0} = {n_st, n_ab};
        u_ctsr_scanner.send(16'h0015, 32'h00000055);
        tick(3);
        chk("ignore", n_st - s0 + n_ab - a0, 0);
        u_ctsr_scanner.send(16'h0016, 32'h00000066);
        tick(3);
        chk("abort", n_ab - a0, 1);
        chk("state", st, CTSR_ST_LINKED);
        u_ctsr_scanner.send(16'h0014, 32'h00000077);
        wstart(CTSR_MV_TARGET, 32'h00000077, 5);
        pw(CTSR_OFS_DELIVERY, CTSR_CMD_RESTORE);
        pulse(1'b0);
        s0 = n_st;
        u_ctsr_scanner.send(16'h0014, 32'h00000077);
        tick(5);
        chk("no resume", n_st - s0, 0);
        $display("test mid run done");
        end_sim();
    end
    // Watchdog well past the expected run of about 530 clocks
    initial begin
        #150000;
        miscompares++;
        end_sim();
    end
endmodule

// ==== hdl/ctsr_top.sv ====
// Connection-timeout safe-run supervisor of a positioning drive.
// Assumes link and motion status come from logic on the same clock; power-up drives rst_n_in.
// Behaviour
// - unchanged control word ignored during mid run
// - control word change interrupts mid run
// - finished mid run never resumes old command
// - bits 1-0 select reaction to lost link
// - loss reaction only after link once existed
// - bits 3-2 pick power-up safe-run delay
// - signed 32-bit safe target for both runs
// - failed safe run retried after interval
// - interval in seconds, zero disables repeat
// - restore command reloads defaults, saves, mid run
`timescale 1ns/1ps

// Timing notes
// All delays run off SEC_CYCLES clocks per second; a short value speeds up simulation.
// Every output is a register, so each reaction shows one clock after its cause.
// Start and abort are one-clock pulses; kind and target hold until the next command.
// The motion profile must latch kind and target on the start pulse.
// Limitations
// Reserved loss reaction 3 behaves like continue; nothing flags it.
// Writing the delay choice while still unlinked restarts the power-up count.
// The nonvolatile save itself lives outside; only its request leaves here.
// Restore reloads defaults in the same edge that starts the mid run.
// Control words are compared whole; any bit change counts as a new command.
module ctsr_top #(
    parameter int SEC_CYCLES = ctsr_pkg::CTSR_SEC_CYC
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Parameter port
    input wire logic par_wr_in,
    input wire logic [7:0] par_addr_in,
    input wire logic [15:0] par_wdata_in,
    output logic [15:0] par_rdata_out,
    // Cyclic link
    input wire logic link_up_in,
    input wire logic ctl_valid_in,
    input wire logic [15:0] ctl_word_in,
    input wire logic [31:0] ctl_target_in,
    // Motion profile handshake
    input wire logic run_done_in,
    input wire logic run_fail_in,
    output ctsr_pkg::ctsr_cmd_t cmd_out,
    output logic save_req_out,
    output logic [2:0] state_out
);
    import ctsr_pkg::*;

    // Supervisor state
    ctsr_state_t state_q;
    ctsr_state_t state_d;

    // Parameter registers
    logic [15:0] cfg_q;
    logic [15:0] repeat_q;
    logic [31:0] safe_q;

    // Change detection of the cyclic control word
    logic [15:0] last_ctl_q;
    logic seen_ctl_q;

    // Second timer: cycles within a second, then whole seconds left
    logic [31:0] cyc_q;
    logic [15:0] sec_q;
    logic retry_q;

    // Registered outputs
    ctsr_cmd_t cmd_q;
    logic save_q;
    logic [15:0] rdata_q;

    // Seconds of delay for a chosen power-up setting
    function automatic logic [15:0] pwr_secs(input logic [1:0] sel);
        case (sel)
            CTSR_PWR_15: pwr_secs = 16'(CTSR_DELAY1_S);
            CTSR_PWR_30: pwr_secs = 16'(CTSR_DELAY2_S);
            default: pwr_secs = 16'(CTSR_DELAY3_S);
        endcase
    endfunction

    // Decode of the parameter port
    // One write strobe per word; the safe target needs two writes, one per half, in either order
    wire wr_cfg = par_wr_in && par_addr_in == CTSR_OFS_CFG;
    wire wr_slo = par_wr_in && par_addr_in == CTSR_OFS_SAFE_LO;
    wire wr_shi = par_wr_in && par_addr_in == CTSR_OFS_SAFE_HI;
    wire wr_rep = par_wr_in && par_addr_in == CTSR_OFS_REPEAT;
    // Other command values on the delivery-state word are ignored here
    wire restore = par_wr_in && par_addr_in == CTSR_OFS_DELIVERY && par_wdata_in == CTSR_CMD_RESTORE;

    // Configuration fields
    wire [1:0] loss_sel = cfg_q[CTSR_LOSS_LSB +: 2];
    wire [1:0] pwr_sel = cfg_q[CTSR_PWR_LSB +: 2];
    // Only a word that differs from the one held counts as a new command
    // The first word after reset always counts, since nothing is held yet
    wire ctl_change = ctl_valid_in && (!seen_ctl_q || ctl_word_in != last_ctl_q);

    // Last cycle of a second, and last second of a count
    wire sec_tick = cyc_q == 32'(SEC_CYCLES - 1);
    wire sec_hit = sec_tick && sec_q == 16'h0001;

    // Read mux; registered so the read port never sees a decode glitch
    // Delivery-state and unmapped numbers read as zero
    wire [15:0] rdata_d = par_addr_in == CTSR_OFS_CFG ? cfg_q :
                          par_addr_in == CTSR_OFS_SAFE_LO ? safe_q[15:0] :
                          par_addr_in == CTSR_OFS_SAFE_HI ? safe_q[31:16] :
                          par_addr_in == CTSR_OFS_REPEAT ? repeat_q :
                          par_addr_in == CTSR_OFS_DELIVERY ? 16'h0000 : 16'h0000;

    // Next state of the supervisor
    // Restore overrides every state, as it must end in a mid run
    always_comb begin
        state_d = state_q;
        case (state_q)
            // No link yet: wait for one, or for the power-up delay
            CTSR_ST_BOOT: begin
                if (link_up_in) begin
                    state_d = CTSR_ST_LINKED;
                end else if (pwr_sel != CTSR_PWR_NONE && sec_hit) begin
                    state_d = CTSR_ST_SAFE;
                end
            end
            // Linked: a drop applies the configured loss reaction
            CTSR_ST_LINKED: begin
                if (!link_up_in) begin
                    state_d = loss_sel == CTSR_LOSS_SAFE ? CTSR_ST_SAFE : CTSR_ST_LOST;
                end
            end
            // Lost: wait for the scanner to come back
            CTSR_ST_LOST: begin
                if (link_up_in) begin
                    state_d = CTSR_ST_LINKED;
                end
            end
            // Safe run: a new word from a live link takes over, done ends it
            // A failed run stays here; the timer decides when to start again
            CTSR_ST_SAFE: begin
                if (link_up_in && ctl_change) begin
                    state_d = CTSR_ST_LINKED;
                end else if (run_done_in) begin
                    state_d = link_up_in ? CTSR_ST_LINKED : CTSR_ST_LOST;
                end
            end
            // Mid run: only a changed word, done or fail ends it
            CTSR_ST_MID: begin
                if (ctl_change || run_done_in || run_fail_in) begin
                    state_d = link_up_in ? CTSR_ST_LINKED : CTSR_ST_LOST;
                end
            end
            default: state_d = CTSR_ST_BOOT;
        endcase
        if (restore) begin
            state_d = CTSR_ST_MID;
        end
    end

    // Parameter registers; restore reloads delivery values
    // Restore wins over a write in the same cycle, as it targets another word
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || restore) begin
            cfg_q <= CTSR_CFG_RST;
            safe_q <= CTSR_SAFE_RST;
            repeat_q <= CTSR_REPEAT_RST;
        end else begin
            if (wr_cfg) begin
                cfg_q <= par_wdata_in;
            end
            if (wr_slo) begin
                safe_q[15:0] <= par_wdata_in;
            end
            if (wr_shi) begin
                safe_q[31:16] <= par_wdata_in;
            end
            if (wr_rep) begin
                repeat_q <= par_wdata_in;
            end
        end
    end

    // Second timer: power-up delay in boot, retry interval after a failed safe run
    // One counter serves both, as the two uses never overlap in time
    // Seconds count down and fire on the last cycle of the last second
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            cyc_q <= 32'h00000000;
            sec_q <= 16'h0000;
            retry_q <= 1'b0;
        end else if (state_q == CTSR_ST_BOOT && state_d == CTSR_ST_BOOT && wr_cfg) begin
            // A new delay choice restarts the count; a stale load would keep the old delay
            cyc_q <= 32'h00000000;
            sec_q <= 16'h0000;
        end else if (state_q == CTSR_ST_BOOT && state_d == CTSR_ST_BOOT) begin
            // Zero seconds left means the count is not loaded yet
            cyc_q <= sec_tick ? 32'h00000000 : cyc_q + 32'h00000001;
            if (sec_q == 16'h0000) begin
                sec_q <= pwr_secs(pwr_sel);
            end else if (sec_tick) begin
                sec_q <= sec_q - 16'h0001;
            end
        end else if (state_q == CTSR_ST_SAFE && run_fail_in && repeat_q != 16'h0000) begin
            retry_q <= 1'b1;
            sec_q <= repeat_q;
            cyc_q <= 32'h00000000;
        end else if (retry_q && state_q == CTSR_ST_SAFE) begin
            // Waiting out the retry interval
            cyc_q <= sec_tick ? 32'h00000000 : cyc_q + 32'h00000001;
            if (sec_tick) begin
                sec_q <= sec_q - 16'h0001;
            end
            if (sec_hit) begin
                retry_q <= 1'b0;
            end
        end else begin
            // Any other state clears the timer so it never carries over
            retry_q <= 1'b0;
            cyc_q <= 32'h00000000;
            sec_q <= 16'h0000;
        end
    end

    // Command generation toward the motion profile
    // Branch order sets priority: mid run, safe run, abort, loss abort, new target
    // Start and abort fall back to zero each cycle, so both stay one-clock pulses
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            state_q <= CTSR_ST_BOOT;
            cmd_q <= '0;
            save_q <= 1'b0;
            last_ctl_q <= 16'h0000;
            seen_ctl_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            rdata_q <= rdata_d;
            save_q <= restore;
            cmd_q.start <= 1'b0;
            cmd_q.abort <= 1'b0;
            // Every valid word is held, also during a mid run
            if (ctl_valid_in) begin
                last_ctl_q <= ctl_word_in;
                seen_ctl_q <= 1'b1;
            end
            // Entry to a mid run starts it at once
            if (state_d == CTSR_ST_MID && state_q != CTSR_ST_MID) begin
                cmd_q <= '{start: 1'b1, abort: 1'b0, kind: CTSR_MV_MID, target: 32'h00000000};
            end else if (state_d == CTSR_ST_SAFE && (state_q != CTSR_ST_SAFE || (retry_q && sec_hit))) begin
                cmd_q <= '{start: 1'b1, abort: 1'b0, kind: CTSR_MV_SAFE, target: safe_q};
            end else if (state_q == CTSR_ST_MID && state_d != CTSR_ST_MID && ctl_change) begin
                cmd_q <= '{start: 1'b0, abort: 1'b1, kind: CTSR_MV_NONE, target: cmd_q.target};
            end else if (state_q == CTSR_ST_LINKED && state_d == CTSR_ST_LOST && loss_sel == CTSR_LOSS_ABORT) begin
                cmd_q.abort <= 1'b1;
                cmd_q.kind <= CTSR_MV_NONE;
            end else if (state_q == CTSR_ST_LINKED && ctl_change) begin
                // Only a changed word starts motion, so a stale 0x14 after a mid run does nothing
                cmd_q <= '{start: 1'b1, abort: 1'b0, kind: CTSR_MV_TARGET, target: ctl_target_in};
            end else if (state_q == CTSR_ST_MID) begin
                cmd_q.kind <= CTSR_MV_MID;
            end
        end
    end

    // Outputs straight from registers
    assign par_rdata_out = rdata_q;
    assign cmd_out = cmd_q;
    assign save_req_out = save_q;
    assign state_out = state_q;
endmodule

// ==== shared/ctsr_pkg.sv ====
// Package for the connection-timeout safe-run supervisor.
// Assumes one 40 MHz clock; parameter port uses 16-bit word writes/reads.
package ctsr_pkg;
    // Parameter numbers used as register offsets
    localparam logic [7:0] CTSR_OFS_CFG = 8'h76;
    localparam logic [7:0] CTSR_OFS_SAFE_LO = 8'h78;
    localparam logic [7:0] CTSR_OFS_SAFE_HI = 8'h79;
    localparam logic [7:0] CTSR_OFS_REPEAT = 8'h7A;
    localparam logic [7:0] CTSR_OFS_DELIVERY = 8'h71;
    // Reset / delivery values
    localparam logic [15:0] CTSR_CFG_RST = 16'h0001;
    localparam logic [31:0] CTSR_SAFE_RST = 32'h00000000;
    localparam logic [15:0] CTSR_REPEAT_RST = 16'h0000;
    // Restore command (-5) to the delivery-state parameter
    localparam logic [15:0] CTSR_CMD_RESTORE = 16'hFFFB;
    // Field positions
    localparam int CTSR_LOSS_LSB = 0;
    localparam int CTSR_PWR_LSB = 2;
    // Loss reactions
    localparam logic [1:0] CTSR_LOSS_CONT = 2'h0;
    localparam logic [1:0] CTSR_LOSS_ABORT = 2'h1;
    localparam logic [1:0] CTSR_LOSS_SAFE = 2'h2;
    // Power-up delay choices
    localparam logic [1:0] CTSR_PWR_NONE = 2'h0;
    localparam logic [1:0] CTSR_PWR_15 = 2'h1;
    localparam logic [1:0] CTSR_PWR_30 = 2'h2;
    // Timing
    localparam int CTSR_CLK_HZ = 40_000_000;
    localparam int CTSR_DELAY1_S = 15;
    localparam int CTSR_DELAY2_S = 30;
    localparam int CTSR_DELAY3_S = 60;
    localparam int CTSR_ONE_S = 1;
    localparam int CTSR_SEC_CYC = CTSR_ONE_S * CTSR_CLK_HZ;

    // Motion command toward the motion profile
    typedef enum logic [1:0] {
        CTSR_MV_NONE = 2'h0,
        CTSR_MV_TARGET = 2'h1,
        CTSR_MV_SAFE = 2'h3,
        CTSR_MV_MID = 2'h2
    } ctsr_mv_t;

    typedef struct packed {
        logic start;
        logic abort;
        ctsr_mv_t kind;
        logic [31:0] target;
    } ctsr_cmd_t;

    // Supervisor states
    typedef enum logic [2:0] {
        CTSR_ST_BOOT = 3'b000,
        CTSR_ST_LINKED = 3'b001,
        CTSR_ST_LOST = 3'b011,
        CTSR_ST_SAFE = 3'b010,
        CTSR_ST_MID = 3'b110
    } ctsr_state_t;
endpackage
